// >>> spi_ext_master.sv
`timescale 1ns/1ps
// ==========================================
// External controller: mode 0, 320 ns bit time
module spi_ext_master (
	output logic sck,
	output logic mosi,
	output logic ss_n,
	input wire logic miso
);
	localparam time HALF = 160;
	initial
	begin
		sck = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
	end
	// Same polarity and phase as the port, clock far below aclk
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#7;
		ss_n = 1'b0;
		#HALF;
		for (int i = 7; i >= 0; i--)
		begin
			mosi = tx[i];
			#HALF;
			sck = 1'b1;
			rx[i] = miso;
			#HALF;
			sck = 1'b0;
		end
		#HALF;
		ss_n = 1'b1;
		// Released line must not look like held data
		mosi = ~mosi;
	endtask
	task automatic blip();
		#7;
		ss_n = 1'b0;
		#(4 * HALF);
		ss_n = 1'b1;
	endtask
	task automatic sel(input logic v);
		#7;
		ss_n = v;
	endtask
endmodule

// >>> spi_pkg.sv
package spi_pkg;

	// ==========================================================
	// Register map (byte addresses on the AXI4-Lite bus)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Field layouts
	typedef struct packed {
		logic rate2;
		logic en;
		logic select_pin_disable;
		logic role;
		logic cpol;
		logic cpha;
		logic rate1;
		logic rate0;
	} ctrl_s;

	typedef struct packed {
		logic done;
		logic rsvd;
		logic ovr;
		logic mode_fault_flag;
		logic txe;
		logic spare;
		logic txeie;
		logic modfie;
	} stat_s;

	localparam ctrl_s CTRL_RST = 8'h14;
	localparam stat_s STAT_RST = 8'h08;

	// Usable master rate codes; half an SCK period is 2**code clocks
	localparam logic [2:0] RATE_MIN = 3'h1;
	localparam logic [2:0] RATE_MAX = 3'h6;
	localparam logic [2:0] CNT_LAST = 3'h7;
	localparam logic [3:0] EDGE_LAST = 4'hF;

	typedef enum logic [1:0] {
		X_IDLE = 2'b01,
		X_BUSY = 2'b10
	} xfer_e;

	// Serial pins, as seen after synchronisation
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} pins_s;

	typedef struct packed {
		ctrl_s ctrl;
		stat_s stat;
		xfer_e st;
		logic [7:0] txbuf;
		logic [7:0] rxbuf;
		logic [7:0] sh;
		logic inbit;
		logic [2:0] cnt;
		logic [3:0] edges;
		logic [6:0] div;
		logic more;
		logic sck_lvl;
		logic sck_prev;
		logic ss_prev;
		logic sel_active;
		logic first_seen;
		logic done_arm;
		logic mode_fault_flag_arm;
		logic awv;
		logic [7:0] aw_addr;
		logic wv;
		logic [7:0] wdata;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_s;

	localparam state_s STATE_RST = '{ctrl: CTRL_RST, stat: STAT_RST, st: X_IDLE, default: '0};

endpackage

// >>> spi_port.sv
`timescale 1ns/1ps
// How it works
// - Four SCK formats picked by polarity and phase bits in the control register.
// - Polarity sets only SCK idle level; data order is unchanged.
// - Phase picks which SCK edges sample and which shift.
// - Phase 0: MSB ready before first edge; SS fall starts the byte.
// - Phase 1: first SCK edge starts the byte; the MSB is already on the line before it.
// - Phase 1 slave takes back-to-back bytes with SS held low.
// - A queued byte follows the current byte with no idle gap.
// - Transmit-empty flag set while buffer free, cleared by a data write.
// - Slave with nothing queued sends back the last received byte.
// - Master mode fault sets flag, requests interrupt, clears enable and role.
// - Mode fault clears on status read with flag set then control write.
// - Master with SS disabled is never faulted and leaves SS alone.
// - Slave faults when SS rises before the byte completes.
// - Slave deselected: MISO released, counter cleared, SCK ignored.
// - Phase-1 slave with SS disabled is always selected and never faulted.
// - Byte arriving while previous unread flags overrun and is dropped.
// - Done flag interrupts when empty-enable clear; empty flag when it is set.
// - Done flag sets per byte; cleared by status read then data access.
// - SS disable affects both roles but not a phase-0 slave.
module spi_port (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_n_in,
	output logic irq
);

	spi_pkg::state_s s_ff;
	spi_pkg::state_s nxt_s;
	spi_pkg::pins_s sy;
	logic sel;
	logic slave_on;
	logic s_edge;
	logic m_tick;
	logic ev;
	logic lead;
	logic sample;
	logic shift;
	logic din;
	logic [7:0] rx_byte;
	logic complete;
	logic ss_rise;
	logic ss_fall;
	logic [2:0] rate;
	logic rate_ok;
	logic [6:0] half_m1;
	logic do_wr;
	logic do_rd;
	logic done_clr;

	// ==========================================================
	// Pin synchronisers
	spi_sync #(
		.W(4)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({sck_in, mosi_in, miso_in, ss_n_in}),
		.dout(sy)
	);

	// ==========================================================
	// Serial event decode
	assign sel = !sy.ss_n || (s_ff.ctrl.select_pin_disable && s_ff.ctrl.cpha);
	assign slave_on = s_ff.ctrl.en && !s_ff.ctrl.role && !(s_ff.ctrl.select_pin_disable && s_ff.ctrl.cpha);
	// Deselected slave ignores SCK entirely
	assign s_edge = (sy.sck != s_ff.sck_prev) && s_ff.ctrl.en && !s_ff.ctrl.role && sel;
	assign m_tick = (s_ff.st == spi_pkg::X_BUSY) && (s_ff.div == '0);
	assign ev = s_ff.ctrl.role ? m_tick : s_edge;
	// Leading edge leaves the idle level, so polarity only moves the reference
	assign lead = (s_ff.ctrl.role ? !s_ff.sck_lvl : sy.sck) != s_ff.ctrl.cpol;
	assign sample = ev && (lead != s_ff.ctrl.cpha);
	// No shift at count zero: keeps a preloaded MSB in place for either phase
	assign shift = ev && (lead == s_ff.ctrl.cpha) && (s_ff.cnt != '0);
	assign din = s_ff.ctrl.role ? sy.miso : sy.mosi;
	assign rx_byte = {s_ff.sh[6:0], din};
	assign complete = sample && (s_ff.cnt == spi_pkg::CNT_LAST);
	assign ss_rise = sy.ss_n && !s_ff.ss_prev;
	assign ss_fall = !sy.ss_n && s_ff.ss_prev;
	assign rate = {s_ff.ctrl.rate2, s_ff.ctrl.rate1, s_ff.ctrl.rate0};
	assign rate_ok = (rate >= spi_pkg::RATE_MIN) && (rate <= spi_pkg::RATE_MAX);
	assign half_m1 = 7'((8'h01 << rate) - 8'h01);

	// ==========================================================
	// Bus handshake
	assign awready = !s_ff.awv && !s_ff.bvalid;
	assign wready = !s_ff.wv && !s_ff.bvalid;
	assign arready = !s_ff.rvalid;
	assign do_wr = s_ff.awv && s_ff.wv && !s_ff.bvalid;
	assign do_rd = arvalid && !s_ff.rvalid;
	assign done_clr = s_ff.done_arm && ((do_rd && araddr == spi_pkg::ADDR_DATA)
		|| (do_wr && s_ff.aw_addr == spi_pkg::ADDR_DATA));

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.sck_prev = sy.sck;
		nxt_s.ss_prev = sy.ss_n;

		if (awvalid && awready)
		begin
			nxt_s.awv = 1'b1;
			nxt_s.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			nxt_s.wv = 1'b1;
			nxt_s.wdata = wdata[7:0];
			nxt_s.wstb = wstrb[0];
		end
		if (s_ff.bvalid && bready)
			nxt_s.bvalid = 1'b0;
		if (do_wr)
		begin
			nxt_s.awv = 1'b0;
			nxt_s.wv = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = spi_pkg::RESP_OKAY;
			case (s_ff.aw_addr)
				spi_pkg::ADDR_CTRL:
				begin
					if (s_ff.wstb)
						nxt_s.ctrl = spi_pkg::ctrl_s'(s_ff.wdata);
					if (s_ff.mode_fault_flag_arm)
						nxt_s.stat.mode_fault_flag = 1'b0;
					nxt_s.mode_fault_flag_arm = 1'b0;
				end
				spi_pkg::ADDR_STAT:
				begin
					if (s_ff.wstb)
					begin
						nxt_s.stat.spare = s_ff.wdata[2];
						nxt_s.stat.txeie = s_ff.wdata[1];
						nxt_s.stat.modfie = s_ff.wdata[0];
					end
				end
				spi_pkg::ADDR_DATA:
				begin
					if (s_ff.wstb)
					begin
						nxt_s.txbuf = s_ff.wdata;
						nxt_s.stat.txe = 1'b0;
					end
				end
				default:
					nxt_s.bresp = spi_pkg::RESP_SLVERR;
			endcase
		end

		if (s_ff.rvalid && rready)
			nxt_s.rvalid = 1'b0;
		if (do_rd)
		begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = spi_pkg::RESP_OKAY;
			nxt_s.rdata = '0;
			case (araddr)
				spi_pkg::ADDR_CTRL:
					nxt_s.rdata[7:0] = s_ff.ctrl;
				spi_pkg::ADDR_STAT:
				begin
					nxt_s.rdata[7:0] = {s_ff.stat.done, 1'b0, s_ff.stat[5:0]};
					nxt_s.done_arm = s_ff.stat.done;
					nxt_s.mode_fault_flag_arm = s_ff.stat.mode_fault_flag;
					nxt_s.stat.ovr = 1'b0;
				end
				spi_pkg::ADDR_DATA:
					nxt_s.rdata[7:0] = s_ff.rxbuf;
				default:
					nxt_s.rresp = spi_pkg::RESP_SLVERR;
			endcase
		end
		if (done_clr)
		begin
			nxt_s.stat.done = 1'b0;
			nxt_s.done_arm = 1'b0;
		end

		// Hardware events come after the bus so that a set beats a clear
		if (!s_ff.ctrl.en)
		begin
			nxt_s.st = spi_pkg::X_IDLE;
			nxt_s.cnt = '0;
			nxt_s.more = 1'b0;
			nxt_s.first_seen = 1'b0;
			nxt_s.sel_active = 1'b0;
			nxt_s.sck_lvl = s_ff.ctrl.cpol;
		end
		else if (s_ff.ctrl.role)
		begin
			case (s_ff.st)
				spi_pkg::X_IDLE:
				begin
					nxt_s.sck_lvl = s_ff.ctrl.cpol;
					nxt_s.cnt = '0;
					if (!s_ff.stat.txe && rate_ok)
					begin
						nxt_s.sh = s_ff.txbuf;
						nxt_s.stat.txe = 1'b1;
						nxt_s.st = spi_pkg::X_BUSY;
						nxt_s.div = half_m1;
						nxt_s.edges = '0;
						nxt_s.more = 1'b0;
					end
				end
				spi_pkg::X_BUSY:
				begin
					nxt_s.more = !s_ff.stat.txe;
					if (m_tick)
					begin
						nxt_s.div = half_m1;
						nxt_s.sck_lvl = !s_ff.sck_lvl;
						nxt_s.edges = s_ff.edges + 4'h1;
						if (s_ff.edges == spi_pkg::EDGE_LAST)
						begin
							// A queued byte goes out on the very next edge
							if (!s_ff.stat.txe)
							begin
								nxt_s.sh = s_ff.txbuf;
								nxt_s.stat.txe = 1'b1;
							end
							else
								nxt_s.st = spi_pkg::X_IDLE;
						end
					end
					else
						nxt_s.div = s_ff.div - 7'h01;
				end
				default:
					nxt_s.st = spi_pkg::X_IDLE;
			endcase
			// Another controller pulling SS low: step back at once
			if (!s_ff.ctrl.select_pin_disable && !sy.ss_n)
			begin
				nxt_s.stat.mode_fault_flag = 1'b1;
				nxt_s.ctrl.en = 1'b0;
				nxt_s.ctrl.role = 1'b0;
				nxt_s.st = spi_pkg::X_IDLE;
			end
		end
		else
		begin
			if (!sel)
			begin
				nxt_s.cnt = '0;
				nxt_s.first_seen = 1'b0;
				nxt_s.sel_active = 1'b0;
			end
			else
			begin
				// The closing edge of a finished byte must not re-arm the fault check
				if ((ss_fall && slave_on) || (s_edge && s_ff.cnt != '0))
					nxt_s.sel_active = 1'b1;
				if (s_edge && s_ff.ctrl.cpha && s_ff.cnt == '0)
					nxt_s.first_seen = 1'b1;
				// Preload before the first edge so the MSB is already on MISO
				if (s_ff.cnt == '0 && !s_ff.first_seen && !s_edge && !s_ff.stat.txe)
				begin
					nxt_s.sh = s_ff.txbuf;
					nxt_s.stat.txe = 1'b1;
				end
			end
			if (slave_on && ss_rise && s_ff.sel_active)
				nxt_s.stat.mode_fault_flag = 1'b1;
		end

		if (shift)
			nxt_s.sh = {s_ff.sh[6:0], s_ff.inbit};
		if (sample)
		begin
			nxt_s.inbit = din;
			nxt_s.cnt = s_ff.cnt + 3'h1;
		end
		if (complete)
		begin
			nxt_s.first_seen = 1'b0;
			nxt_s.sel_active = 1'b0;
			if (nxt_s.stat.done)
				nxt_s.stat.ovr = 1'b1;
			else
				nxt_s.rxbuf = rx_byte;
			nxt_s.stat.done = 1'b1;
			if (!s_ff.ctrl.role)
			begin
				if (!s_ff.stat.txe)
				begin
					nxt_s.sh = s_ff.txbuf;
					nxt_s.stat.txe = 1'b1;
				end
				else
					nxt_s.sh = rx_byte;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_ff <= spi_pkg::STATE_RST;
		else
			s_ff <= nxt_s;
	end

	// ==========================================================
	// Outputs
	assign bvalid = s_ff.bvalid;
	assign bresp = s_ff.bresp;
	assign rvalid = s_ff.rvalid;
	assign rresp = s_ff.rresp;
	assign rdata = s_ff.rdata;
	assign sck_out = s_ff.sck_lvl;
	assign sck_oe = s_ff.ctrl.en && s_ff.ctrl.role;
	assign mosi_out = s_ff.sh[7];
	assign mosi_oe = s_ff.ctrl.en && s_ff.ctrl.role;
	assign miso_out = s_ff.sh[7];
	assign miso_oe = s_ff.ctrl.en && !s_ff.ctrl.role && sel;
	assign irq = (s_ff.stat.done && !s_ff.stat.txeie) || (s_ff.stat.txe && s_ff.stat.txeie)
		|| (s_ff.stat.mode_fault_flag && s_ff.stat.modfie);

	// ==========================================================
	// Checks
	a_miso_release: assert property (@(posedge aclk) disable iff (!aresetn)
		sy.ss_n && !(s_ff.ctrl.select_pin_disable && s_ff.ctrl.cpha) |-> !miso_oe)
		else $error("MISO driven while deselected");
	a_mode_fault_flag_disables: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_ff.stat.mode_fault_flag) && $past(s_ff.ctrl.role) |-> !s_ff.ctrl.en && !s_ff.ctrl.role)
		else $error("Master fault left port enabled");
	a_select_pin_disable_no_fault: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ff.ctrl.en && s_ff.ctrl.role && s_ff.ctrl.select_pin_disable && !s_ff.stat.mode_fault_flag |=> !s_ff.stat.mode_fault_flag)
		else $error("Fault with select disabled");
	a_ovr_keeps_data: assert property (@(posedge aclk) disable iff (!aresetn)
		complete && s_ff.stat.done && !done_clr |=> s_ff.stat.ovr && $stable(s_ff.rxbuf))
		else $error("Overrun lost the unread byte");
	a_done_on_byte: assert property (@(posedge aclk) disable iff (!aresetn)
		complete |=> s_ff.stat.done)
		else $error("Done flag missing after byte");
	a_txe_on_write: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr && s_ff.aw_addr == spi_pkg::ADDR_DATA && s_ff.wstb && !s_ff.ctrl.en |=> !s_ff.stat.txe)
		else $error("Data write left buffer empty");
	a_mode_fault_flag_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ff.stat.mode_fault_flag && s_ff.stat.modfie |-> irq)
		else $error("Fault request not merged");
	c_slave_byte: cover property (@(posedge aclk) disable iff (!aresetn)
		complete && !s_ff.ctrl.role);
	c_master_queue: cover property (@(posedge aclk) disable iff (!aresetn)
		m_tick && s_ff.edges == spi_pkg::EDGE_LAST && s_ff.more);
	c_mode_fault: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_ff.stat.mode_fault_flag));

endmodule

// >>> spi_sync.sv
`timescale 1ns/1ps
module spi_sync #(
	parameter int W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] second;
		logic [W-1:0] first;
	} sync_s;

	sync_s s_ff;
	sync_s nxt_s;

	// The first stage feeds only the second; nothing else may look at it
	always_comb
	begin
		nxt_s.first = din;
		nxt_s.second = s_ff.first;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign dout = s_ff.second;

endmodule

// >>> tb_spi_port.sv
`timescale 1ns/1ps
module tb_spi_port;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, rx;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
	logic sck_w, mosi_w, ss_w, miso_last, miso_w;
	int fail_count, tests_run;
	initial aclk = 1'b0;
	always #20 aclk = ~aclk;
	// Undriven MISO shows the inverse of its last value
	assign miso_w = miso_oe ? miso_out : ~miso_last;
	always @(posedge aclk) if (miso_oe) miso_last <= miso_out;
	spi_port u_spi_port (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sck_in(sck_oe ? sck_out : sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
		.mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
		.miso_oe(miso_oe), .ss_n_in(ss_w), .irq(irq));
	spi_ext_master u_spi_ext_master (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .miso(miso_w));
	// ==========================================
	// Bus tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [7:0] d);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready && !ad)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !dd)
			begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid);
		chk("bresp", {30'h0, bresp}, {30'h0, spi_pkg::RESP_OKAY});
	endtask
	task automatic axr(input string nm, input logic [7:0] a, input logic [7:0] e,
		input logic [1:0] r = spi_pkg::RESP_OKAY);
		logic ad;
		ad = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready && !ad)
			begin
				ad = 1'b1;
				arvalid <= 1'b0;
			end
		end
		while (!rvalid);
		chk("rresp", {30'h0, rresp}, {30'h0, r});
		if (r === spi_pkg::RESP_OKAY)
			chk(nm, {24'h0, rdata[7:0]}, {24'h0, e});
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================
	// Tests
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, miso_last} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		fail_count = 0;
		tests_run = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr("ctrl rst", spi_pkg::ADDR_CTRL, 8'h14);
		axr("stat rst", spi_pkg::ADDR_STAT, 8'h08);
		axr("unmapped", 8'h0C, 8'h00, spi_pkg::RESP_SLVERR);
		chk("irq idle", {31'h0, irq}, 32'h0);
		axw(spi_pkg::ADDR_CTRL, 8'h00);
		axw(spi_pkg::ADDR_CTRL, 8'h40);
		chk("miso off", {31'h0, miso_oe}, 32'h0);
		axw(spi_pkg::ADDR_DATA, 8'hA5);
		u_spi_ext_master.xfer(8'h3C, rx);
		chk("miso byte", {24'h0, rx}, 32'hA5);
		repeat (10) @(posedge aclk);
		chk("irq done", {31'h0, irq}, 32'h1);
		axr("stat done", spi_pkg::ADDR_STAT, 8'h88);
		// Leave the byte unread so the next one overruns
		u_spi_ext_master.xfer(8'h5A, rx);
		chk("echo", {24'h0, rx}, 32'h3C);
		repeat (10) @(posedge aclk);
		axr("stat ovr", spi_pkg::ADDR_STAT, 8'hA8);
		axr("data kept", spi_pkg::ADDR_DATA, 8'h3C);
		axr("stat clr", spi_pkg::ADDR_STAT, 8'h08);
		u_spi_ext_master.blip();
		repeat (10) @(posedge aclk);
		axr("slave mode_fault_flag", spi_pkg::ADDR_STAT, 8'h18);
		axw(spi_pkg::ADDR_CTRL, 8'h40);
		axr("mode_fault_flag clr", spi_pkg::ADDR_STAT, 8'h08);
		axw(spi_pkg::ADDR_CTRL, 8'h31);
		axw(spi_pkg::ADDR_CTRL, 8'h71);
		u_spi_ext_master.sel(1'b0);
		repeat (10) @(posedge aclk);
		axr("select_pin_disable ctrl", spi_pkg::ADDR_CTRL, 8'h71);
		axr("select_pin_disable stat", spi_pkg::ADDR_STAT, 8'h08);
		axw(spi_pkg::ADDR_CTRL, 8'h11);
		axw(spi_pkg::ADDR_CTRL, 8'h51);
		repeat (10) @(posedge aclk);
		axr("fault ctrl", spi_pkg::ADDR_CTRL, 8'h01);
		axr("fault stat", spi_pkg::ADDR_STAT, 8'h18);
		u_spi_ext_master.sel(1'b1);
		repeat (4) @(posedge aclk);
		axw(spi_pkg::ADDR_CTRL, 8'h01);
		axr("fault clr", spi_pkg::ADDR_STAT, 8'h08);
		axw(spi_pkg::ADDR_CTRL, 8'h11);
		axw(spi_pkg::ADDR_CTRL, 8'h51);
		axw(spi_pkg::ADDR_DATA, 8'h96);
		axw(spi_pkg::ADDR_DATA, 8'h69);
		repeat (200) @(posedge aclk);
		axr("queued pair", spi_pkg::ADDR_STAT, 8'hA8);
		chk("irq master", {31'h0, irq}, 32'h1);
		chk("sck idle", {31'h0, sck_out}, 32'h0);
		chk("mosi drive", {31'h0, mosi_oe}, 32'h1);
		wrap_up();
	end
	initial
	begin
		#2000000;
		fail_count++;
		wrap_up();
	end
endmodule
